// >>> core/crs_pkg.sv
// Constants, types and the rate table for the conversion rate scheduler
package crs_pkg;
    // Register pointer addresses and reset value
    localparam logic [7:0] CRS_RATE_ADDR = 8'h0b;
    localparam logic [7:0] CRS_ONESHOT_ADDR = 8'h0f;
    localparam logic [7:0] CRS_RATE_RESET = 8'h07;
    localparam logic [7:0] CRS_READ_ZERO = 8'h00;
    // Rate code field: low three bits select, upper five must be zero
    localparam int CRS_CODE_LSB = 0;
    localparam int CRS_CODE_MSB = 2;
    localparam int CRS_UPPER_LSB = 3;
    localparam int CRS_UPPER_MSB = 7;
    localparam logic [2:0] CRS_FASTEST_CODE = 3'h7;
    // Serial target address of the triple-remote variant as wired by default
    localparam logic [6:0] CRS_TARGET_ADDR = 7'h4c;
    // Time base: one tick per millisecond
    localparam int CRS_CLK_MHZ = 50;
    localparam int CRS_TICK_US = 1000;
    localparam int CRS_TICK_CYCLES = CRS_TICK_US * CRS_CLK_MHZ;
    // Fixed length of one channel conversion
    localparam int CRS_CONV_MS = 125;
    localparam logic [6:0] CRS_CONV_LAST = 7'(CRS_CONV_MS - 1);
    // Sequence period per rate code, 16 s down to 125 ms
    localparam logic [14:0] CRS_PERIOD_MS [8] = '{
        15'h3e80, 15'h1f40, 15'h0fa0, 15'h07d0,
        15'h03e8, 15'h01f4, 15'h00fa, 15'h007d
    };
    localparam logic [14:0] CRS_SEQ_MS_MAX = 15'h7fff;
    localparam int CRS_NUM_CH = 4;
    // Register access request from the serial engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } crs_reg_req_t;
    // Channel enables, bit 0 local then remote one to three
    typedef struct packed {
        logic remote_three_enable;
        logic remote_two_enable;
        logic remote_one_enable;
        logic local_channel_enable;
    } crs_chan_en_t;
    typedef enum logic [1:0] {CRS_IDLE, CRS_CONV, CRS_SHUT} crs_state_t;
endpackage : crs_pkg

// >>> core/crs_tick_div.sv
// Divider that makes a one-cycle enable pulse every CYCLES clocks
`timescale 1ns/1ps
module crs_tick_div #(
    parameter int CYCLES = 50000
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Enable pulse
    output logic tick
);
    logic [16:0] cnt_q;

    // Free-running count; wraps so the pulse period is exact
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cnt_q <= 17'h00000;
            tick <= 1'b0;
        end else if (cnt_q == 17'(CYCLES - 1)) begin
            cnt_q <= 17'h00000;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 17'h00001;
            tick <= 1'b0;
        end
    end
endmodule : crs_tick_div

// >>> core/crs_scheduler.sv
// Conversion rate register and measurement sequence pacing
`timescale 1ns/1ps
// What this block does
// (RULE1) Rate register at 0Bh, resets to 07h
// (RULE2) Rate changes idle time, never conversion length
// (RULE3) One-shot in idle starts sequence at once
// (RULE4) Codes 0..7 give 1/16 to 8 per second
// (RULE5) Code 6 slows with three or four channels
// (RULE6) Code 7 slows with two or more channels
// (RULE7) Answers serial target address 1001 100
// (RULE8) Order local, remote one to three, wait
// (RULE9) Shutdown finishes sequence, clearing resumes
// (RULE10) One-shot while shut down, then shut again
// (RULE11) Disabled channels are skipped in sequence
// (RULE12) Undefined codes act as the fastest setting
module crs_scheduler #(
    parameter int TICK_CYCLES = crs_pkg::CRS_TICK_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Register access from the serial engine
    input crs_pkg::crs_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Serial address match
    input wire logic [6:0] target_addr,
    output logic addr_hit,
    // Configuration bits from the other configuration registers
    input wire logic shutdown_request,
    input crs_pkg::crs_chan_en_t chan_en,
    // Converter control and status
    output logic conv_start,
    output logic [1:0] conv_channel,
    output logic busy,
    output logic seq_done
);
    import crs_pkg::*;

    logic [7:0] rate_q;
    logic [2:0] code;
    logic [14:0] period_ms;
    logic ms_tick;
    crs_state_t st_q;
    logic [1:0] ch_q;
    logic [6:0] conv_ms_q;
    logic [14:0] seq_ms_q;
    logic [3:0] en;
    logic [2:0] first_ch;
    logic [2:0] next_ch;
    logic oneshot_wr;
    logic conv_done;
    logic idle_over;
    logic begin_seq;
    logic to_shut;

    // Lowest enabled channel at or above a start index; bit 2 flags a find
    function automatic logic [2:0] find_ch(input logic [3:0] mask, input logic [2:0] from);
        logic [2:0] r;
        r = 3'h0;
        for (int i = CRS_NUM_CH - 1; i >= 0; i--) begin
            if (mask[i] && 3'(i) >= from) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction : find_ch

    crs_tick_div #(.CYCLES(TICK_CYCLES)) u_tick (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .tick(ms_tick)
    );

    // Address match is a plain compare, the strap-free default wiring
    assign addr_hit = (target_addr == CRS_TARGET_ADDR); // [RULE7]

    // Rate register write; stored as written so readback is faithful
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rate_q <= CRS_RATE_RESET; // [RULE1]
        end else if (reg_req.wr && reg_req.addr == CRS_RATE_ADDR) begin
            rate_q <= reg_req.wdata; // [RULE1]
        end
    end

    // Readback; other pointers read zero here
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            reg_rdata <= CRS_READ_ZERO;
        end else if (reg_req.rd) begin
            reg_rdata <= (reg_req.addr == CRS_RATE_ADDR) ? rate_q : CRS_READ_ZERO; // [RULE1]
        end
    end

    // Rate decode; undefined codes are clamped to the fastest period
    always_comb begin
        if (rate_q[CRS_UPPER_MSB:CRS_UPPER_LSB] != 5'h00) begin
            code = CRS_FASTEST_CODE; // [RULE12]
        end else begin
            code = rate_q[CRS_CODE_MSB:CRS_CODE_LSB];
        end
        period_ms = CRS_PERIOD_MS[code]; // [RULE4]
    end

    // Sequencing decisions
    always_comb begin
        en = chan_en; // [RULE11]
        first_ch = find_ch(en, 3'h0); // [RULE8]
        next_ch = find_ch(en, {1'b0, ch_q} + 3'h1); // [RULE8] [RULE11]
        oneshot_wr = reg_req.wr && reg_req.addr == CRS_ONESHOT_ADDR;
        conv_done = st_q == CRS_CONV && ms_tick && conv_ms_q == CRS_CONV_LAST; // [RULE2]
        // Period is timed from sequence start, so long sequences leave no idle
        idle_over = seq_ms_q >= period_ms; // [RULE5] [RULE6]
        begin_seq = (st_q == CRS_IDLE && (oneshot_wr || (!shutdown_request && idle_over)))
            || (st_q == CRS_SHUT && (oneshot_wr || !shutdown_request)); // [RULE3] [RULE9] [RULE10]
        to_shut = st_q == CRS_IDLE && !oneshot_wr && shutdown_request; // [RULE9]
    end

    // Sequence state and channel pointer
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q <= CRS_IDLE;
            ch_q <= 2'h0;
        end else begin
            unique case (st_q)
                CRS_CONV: begin
                    if (conv_done && next_ch[2]) begin
                        ch_q <= next_ch[1:0]; // [RULE8]
                    end else if (conv_done) begin
                        // Sequence ends here even if shutdown arrived mid-way
                        st_q <= shutdown_request ? CRS_SHUT : CRS_IDLE; // [RULE9] [RULE10]
                    end
                end
                CRS_IDLE, CRS_SHUT: begin
                    if (begin_seq && first_ch[2]) begin
                        st_q <= CRS_CONV; // [RULE3]
                        ch_q <= first_ch[1:0];
                    end else if (to_shut) begin
                        st_q <= CRS_SHUT; // [RULE9]
                    end else if (begin_seq) begin
                        // Nothing enabled: wait a full period again
                        st_q <= CRS_IDLE;
                    end
                end
                // Unused encoding: fall back to a clean idle
                default: begin
                    st_q <= CRS_IDLE;
                end
            endcase
        end
    end

    // Conversion timer, identical for every rate code
    always_ff @(posedge sys_clk) begin
        if (!resetn || begin_seq || conv_done) begin
            conv_ms_q <= 7'h00; // [RULE2]
        end else if (st_q == CRS_CONV && ms_tick) begin
            conv_ms_q <= conv_ms_q + 7'h01;
        end
    end

    // Time since sequence start; reset value forces a start at once
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            seq_ms_q <= CRS_SEQ_MS_MAX;
        end else if (begin_seq) begin
            seq_ms_q <= 15'h0000;
        end else if (ms_tick && seq_ms_q != CRS_SEQ_MS_MAX) begin
            seq_ms_q <= seq_ms_q + 15'h0001;
        end
    end

    // Converter strobes
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            conv_start <= 1'b0;
            seq_done <= 1'b0;
        end else begin
            conv_start <= (begin_seq && first_ch[2]) || (conv_done && next_ch[2]);
            seq_done <= conv_done && !next_ch[2];
        end
    end

    assign busy = st_q == CRS_CONV;
    assign conv_channel = ch_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    rate_reset_a: assert property ($past(!resetn) |-> rate_q == 8'h07) // [RULE1]
        else $error("rate register not at reset value");
    rate_readback_a: assert property (reg_req.rd && reg_req.addr == CRS_RATE_ADDR
        |=> reg_rdata == $past(rate_q)) // [RULE1]
        else $error("rate readback mismatch");
    conv_length_a: assert property (busy && conv_ms_q != CRS_CONV_LAST |=> busy) // [RULE2]
        else $error("conversion ended early");
    oneshot_idle_a: assert property (st_q == CRS_IDLE && oneshot_wr && first_ch[2]
        |=> st_q == CRS_CONV && conv_start && {1'b1, ch_q} == $past(first_ch)) // [RULE3]
        else $error("one-shot did not start a sequence");
    rate_decode_a: assert property (rate_q[7:3] == 5'h00
        |-> period_ms == (15'd16000 >> rate_q[2:0])) // [RULE4]
        else $error("rate code period wrong");
    fast_clamp_a: assert property (rate_q[7:3] != 5'h00 |-> period_ms == 15'd125) // [RULE12]
        else $error("undefined code not fastest");
    idle_hold_a: assert property (st_q == CRS_IDLE && !oneshot_wr && seq_ms_q < period_ms
        && !shutdown_request |=> st_q == CRS_IDLE) // [RULE5] [RULE6]
        else $error("idle ended early");
    shut_hold_a: assert property (st_q == CRS_SHUT && shutdown_request && !oneshot_wr
        |=> st_q == CRS_SHUT) // [RULE9]
        else $error("conversion while shut down");
    shut_finish_a: assert property (busy && shutdown_request && conv_done && !next_ch[2]
        |=> st_q == CRS_SHUT) // [RULE9] [RULE10]
        else $error("did not return to shutdown");
    chan_enabled_a: assert property (conv_start && $stable(chan_en) |-> en[conv_channel]) // [RULE11]
        else $error("disabled channel converted");
    chan_order_a: assert property (busy && conv_done && next_ch[2]
        |=> conv_channel > $past(conv_channel)) // [RULE8]
        else $error("channel order broken");
    addr_match_a: assert property (addr_hit == (target_addr == 7'b1001100)) // [RULE7]
        else $error("target address mismatch");

    seq_cover_c: cover property (seq_done ##[1:300] conv_start);
    oneshot_cover_c: cover property (st_q == CRS_SHUT && oneshot_wr ##1 busy);
    shut_cover_c: cover property (busy && shutdown_request ##1 st_q == CRS_SHUT);
endmodule : crs_scheduler

// >>> test/crs_host_model.sv
// Serial host model that reads and writes scheduler registers by pointer
`timescale 1ns/1ps
module crs_host_model (
    // Clock
    input wire logic sys_clk,
    // Register access
    output crs_pkg::crs_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
    import crs_pkg::*;
    initial reg_req = '0;
    // Strobe held for one taking edge; released fields show inverted data
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : write
    // Data is registered, so it is taken 1 ns after the edge that samples the strobe
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        #1 d = reg_rdata;
    endtask : read
    // Single sequence request, legal in idle or while shut down
    task automatic one_shot();
        write(CRS_ONESHOT_ADDR, 8'h00);
    endtask : one_shot
endmodule : crs_host_model

// >>> test/test_conversion_rate_scheduler.sv
// Self-checking bench for the conversion rate scheduler
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("Error at %0t: got %0h exp %0h", $time, a, b); end end
module test_conversion_rate_scheduler;
    import crs_pkg::*;
    localparam int TICK = 4;
    localparam int CONV = CRS_CONV_MS * TICK;
    logic sys_clk = 0, resetn = 0, shutdown_request = 0, addr_hit, conv_start, busy, seq_done;
    logic [6:0] target_addr = 7'h00;
    logic [7:0] reg_rdata, v, d;
    logic [1:0] conv_channel;
    crs_reg_req_t reg_req;
    crs_chan_en_t chan_en = 4'h1;
    int err_count = 0, tests_run = 0, cyc = 0, seed = 32'h699b, t0, t1;
    logic [7:0] codes [9] = '{8'h07, 8'h07, 8'h07, 8'h07, 8'h06, 8'h06, 8'h06, 8'h05, 8'h28};
    logic [3:0] ens [9] = '{4'h1, 4'h3, 4'h7, 4'hf, 4'h3, 4'h7, 4'hf, 4'h5, 4'h2};
    crs_scheduler #(.TICK_CYCLES(TICK)) crs_scheduler_inst (.sys_clk(sys_clk),
        .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .target_addr(target_addr), .addr_hit(addr_hit), .shutdown_request(shutdown_request),
        .chan_en(chan_en), .conv_start(conv_start), .conv_channel(conv_channel),
        .busy(busy), .seq_done(seq_done));
    crs_host_model host (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
    // 50 MHz clock and a free cycle count for interval checks
    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    // Period in cycles: rate period, stretched when the channels cannot fit
    function automatic int exp_cycles(input logic [7:0] code, input int n);
        int ms;
        ms = (code > 8'h07) ? 125 : 16000 >> code;
        if (CRS_CONV_MS * n > ms) ms = CRS_CONV_MS * n;
        return ms * TICK;
    endfunction : exp_cycles
    // Tick phase jitter allows a small slack around each interval
    function automatic logic near(input int got, input int exp);
        return (got >= exp - 6) && (got <= exp + 6);
    endfunction : near
    task automatic end_of_test();
        $display("Checks run %0d, errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // Bounded wait for a start pulse (done=0) or a sequence end pulse (done=1)
    task automatic wait_sig(input bit done, input int lim);
        int i;
        i = 0;
        do begin
            @(posedge sys_clk);
            #1 i++;
        end while ((done ? seq_done : conv_start) !== 1'b1 && i < lim);
        if ((done ? seq_done : conv_start) !== 1'b1) begin
            err_count++;
            $display("Error at %0t: pulse never came", $time);
            end_of_test();
        end
    endtask : wait_sig
    // Follows one sequence, checking channel order and conversion length
    task automatic run_seq(input logic [3:0] en, output int ts);
        int t;
        bit first;
        first = 1;
        for (int c = 0; c < 4; c++) if (en[c]) begin
            wait_sig(0, 70000);
            `CHK(conv_channel, 2'(c))
            if (first) ts = cyc;
            else `CHK(near(cyc - t, CONV), 1'b1)
            first = 0;
            t = cyc;
        end
        wait_sig(1, CONV + 10);
        `CHK(near(cyc - t, CONV), 1'b1)
    endtask : run_seq
    // Watches for a stretch with no conversion at all
    task automatic quiet(input int n);
        int hits;
        hits = 0;
        repeat (n) begin
            @(posedge sys_clk);
            #1 hits += (conv_start !== 1'b0 || busy !== 1'b0);
        end
        `CHK(hits, 0)
    endtask : quiet
    // Waits out the sequence that straddles the change, so checks see clean sequences
    task automatic cfg(input logic [7:0] code, input logic [3:0] en);
        host.write(CRS_RATE_ADDR, code);
        @(posedge sys_clk) chan_en <= en;
        wait_sig(1, 70000);
    endtask : cfg
    // Main sequence: registers, address match, rates, one-shot, shutdown
    initial begin
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        host.read(CRS_RATE_ADDR, d);
        `CHK(d, CRS_RATE_RESET)
        host.read(8'h0c, d);
        `CHK(d, 8'h00)
        repeat (6) begin
            v = 8'($random(seed));
            host.write(CRS_RATE_ADDR, v);
            host.read(CRS_RATE_ADDR, d);
            `CHK(d, v)
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk) target_addr <= (i == 3) ? 7'b1001100 : 7'($random(seed));
            #1 `CHK(addr_hit, target_addr == 7'b1001100)
        end
        // Two whole sequences on the new settings give one start-to-start interval
        for (int i = 0; i < 9; i++) begin
            cfg(codes[i], ens[i]);
            run_seq(ens[i], t0);
            run_seq(ens[i], t1);
            `CHK(near(t1 - t0, exp_cycles(codes[i], $countones(ens[i]))), 1'b1)
        end
        cfg(8'h04, 4'h1);
        run_seq(4'h1, t0);
        t0 = cyc;
        // Watch in parallel: the start pulse rises on the edge the write returns on
        fork
            host.one_shot();
            wait_sig(0, 6);
        join
        `CHK(cyc - t0 <= 6, 1'b1)
        // Shutdown raised in mid-sequence: the sequence completes, then silence
        cfg(8'h07, 4'h3);
        wait_sig(0, 70000);
        @(posedge sys_clk) shutdown_request <= 1'b1;
        wait_sig(1, 2 * CONV + 10);
        quiet(3000);
        fork
            host.one_shot();
            run_seq(4'h3, t0);
        join
        quiet(3000);
        @(posedge sys_clk) shutdown_request <= 1'b0;
        wait_sig(0, 6);
        `CHK(conv_channel, 2'd0)
        end_of_test();
    end
endmodule : test_conversion_rate_scheduler
